// ---- out_cfg_defs.svh ----
`ifndef OUT_CFG_DEFS_SVH
`define OUT_CFG_DEFS_SVH

// register offsets (byte addresses on the configuration port)
`define OFS_PAGE_RESET 8'h00
`define OFS_BAND_SEL 8'h42
`define OFS_ENC_SEL 8'h43
`define OFS_GAIN 8'h44
`define OFS_ENC_EN 8'h4B
`define OFS_BAND_EN 8'h4E
`define OFS_GAIN_EN 8'h52

// field positions
`define BIT_PAGE_RESET 0
`define BIT_ENC_SEL 0
`define BIT_ENC_EN 5
`define BIT_BAND_EN 7
`define BIT_GAIN_EN 0

// writable-bit masks
`define MSK_PAGE_RESET 8'h01
`define MSK_BAND_SEL 8'h07
`define MSK_ENC_SEL 8'h01
`define MSK_GAIN 8'hFF
`define MSK_ENC_EN 8'h20
`define MSK_BAND_EN 8'h80
`define MSK_GAIN_EN 8'h01

`define REG_RESET 8'h00
`define GAIN_UNITY 7'h20

`endif

// ---- out_cfg_pkg.sv ----
package out_cfg_pkg;

   typedef enum logic [1:0] {
      ZONE_FIRST = 2'b00,
      ZONE_SECOND = 2'b01,
      ZONE_THIRD = 2'b10,
      ZONE_NONE = 2'b11
   } band_zone_t;

   typedef enum logic [0:0] {
      ENC_TWOS = 1'b0,
      ENC_OFFSET = 1'b1
   } sample_enc_t;

   typedef struct packed {
      band_zone_t zone;
      logic zone_valid;
      sample_enc_t encoding;
      logic gain_on;
      logic [6:0] gain_code;
   } active_cfg_t;

endpackage

// ---- output_config_registers.sv ----
// Functional notes
// - band codes 000/001/010 map zones, others unused
// - band select acts only with band enable
// - format bit: 0 twos, 1 offset binary
// - format enable clear forces twos complement
// - 7-bit gain code, dB = 20log(code/32)
// - gain code used only with gain enable
// - settings apply on page reset 0-1-0 pulse
`timescale 1ns/100ps
`default_nettype none
`include "out_cfg_defs.svh"

module output_config_registers
   import out_cfg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   output active_cfg_t o_cfg,
   output logic o_cfg_applied
);

   // shadow registers as written by software
   logic [7:0] sample_band_select_reg;
   logic [7:0] output_encoding_select_reg;
   logic [7:0] signal_gain_setting_reg;
   logic [7:0] encoding_control_enable_reg;
   logic [7:0] band_enable_reg;
   logic [7:0] gain_enable_reg;
   logic [7:0] page_reset_reg;
   active_cfg_t cfg_next;

   function automatic logic hit(input logic [7:0] ofs);
      hit = i_wr && (i_addr == ofs);
   endfunction

   function automatic band_zone_t decode_zone(input logic [2:0] code);
      unique case (code)
         3'b000: decode_zone = ZONE_FIRST;
         3'b001: decode_zone = ZONE_SECOND;
         3'b010: decode_zone = ZONE_THIRD;
         default: decode_zone = ZONE_NONE;
      endcase
   endfunction

   // only documented writable bits are stored; the rest read zero
   always_ff @(posedge i_clk) begin
      if (!i_resetn)
         sample_band_select_reg <= `REG_RESET;
      else if (hit(`OFS_BAND_SEL))
         sample_band_select_reg <= i_wdata & `MSK_BAND_SEL;
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn)
         output_encoding_select_reg <= `REG_RESET;
      else if (hit(`OFS_ENC_SEL))
         output_encoding_select_reg <= i_wdata & `MSK_ENC_SEL;
   end

   // bit 7 is kept for read-back only; it never reaches the gain code
   always_ff @(posedge i_clk) begin
      if (!i_resetn)
         signal_gain_setting_reg <= `REG_RESET;
      else if (hit(`OFS_GAIN))
         signal_gain_setting_reg <= i_wdata & `MSK_GAIN;
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn)
         encoding_control_enable_reg <= `REG_RESET;
      else if (hit(`OFS_ENC_EN))
         encoding_control_enable_reg <= i_wdata & `MSK_ENC_EN;
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn)
         band_enable_reg <= `REG_RESET;
      else if (hit(`OFS_BAND_EN))
         band_enable_reg <= i_wdata & `MSK_BAND_EN;
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn)
         gain_enable_reg <= `REG_RESET;
      else if (hit(`OFS_GAIN_EN))
         gain_enable_reg <= i_wdata & `MSK_GAIN_EN;
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn)
         page_reset_reg <= `REG_RESET;
      else if (hit(`OFS_PAGE_RESET))
         page_reset_reg <= i_wdata & `MSK_PAGE_RESET;
   end

   always_comb begin
      cfg_next.zone_valid = band_enable_reg[`BIT_BAND_EN];
      cfg_next.zone = decode_zone(sample_band_select_reg[2:0]);
      // without enable the block stays at first zone (reset default)
      if (!cfg_next.zone_valid)
         cfg_next.zone = ZONE_FIRST;
      cfg_next.encoding = (encoding_control_enable_reg[`BIT_ENC_EN] &&
                           output_encoding_select_reg[`BIT_ENC_SEL]) ? ENC_OFFSET : ENC_TWOS;
      cfg_next.gain_on = gain_enable_reg[`BIT_GAIN_EN];
      // gain code passes raw; datapath applies 20log(code/32)
      cfg_next.gain_code = cfg_next.gain_on ? signal_gain_setting_reg[6:0] : `GAIN_UNITY;
   end

   // settings reach the datapath only on the falling edge of the
   // page reset bit, so half-written setups are never seen
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_cfg <= '{zone: ZONE_FIRST, zone_valid: 1'b0, encoding: ENC_TWOS, gain_on: 1'b0,
                    gain_code: `GAIN_UNITY};
         o_cfg_applied <= 1'b0;
      end else begin
         o_cfg_applied <= 1'b0;
         if (hit(`OFS_PAGE_RESET) && page_reset_reg[`BIT_PAGE_RESET] && !i_wdata[`BIT_PAGE_RESET]) begin
            o_cfg <= cfg_next;
            o_cfg_applied <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn)
         o_rdata <= 8'h00;
      else if (i_rd) begin
         unique case (i_addr)
            `OFS_PAGE_RESET: o_rdata <= page_reset_reg;
            `OFS_BAND_SEL: o_rdata <= sample_band_select_reg;
            `OFS_ENC_SEL: o_rdata <= output_encoding_select_reg;
            `OFS_GAIN: o_rdata <= signal_gain_setting_reg;
            `OFS_ENC_EN: o_rdata <= encoding_control_enable_reg;
            `OFS_BAND_EN: o_rdata <= band_enable_reg;
            `OFS_GAIN_EN: o_rdata <= gain_enable_reg;
            default: o_rdata <= 8'h00;
         endcase
      end else
         o_rdata <= 8'h00;
   end

   // read path: the answer stands only in the cycle after the strobe
   a_read_idle: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !i_rd
      |=> o_rdata == 8'h00)
      else $error("read data not zero without read");
   a_read_page_reset: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_rd && i_addr == `OFS_PAGE_RESET
      |=> o_rdata == $past(page_reset_reg))
      else $error("page reset read back wrong");
   a_read_band: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_rd && i_addr == `OFS_BAND_SEL
      |=> o_rdata == $past(sample_band_select_reg))
      else $error("band select read back wrong");
   a_read_format: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_rd && i_addr == `OFS_ENC_SEL
      |=> o_rdata == $past(output_encoding_select_reg))
      else $error("format select read back wrong");
   a_read_gain: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_rd && i_addr == `OFS_GAIN
      |=> o_rdata == $past(signal_gain_setting_reg))
      else $error("gain setting read back wrong");
   a_read_format_enable: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_rd && i_addr == `OFS_ENC_EN
      |=> o_rdata == $past(encoding_control_enable_reg))
      else $error("format enable read back wrong");
   a_read_band_enable: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_rd && i_addr == `OFS_BAND_EN
      |=> o_rdata == $past(band_enable_reg))
      else $error("band enable read back wrong");
   a_read_gain_enable: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_rd && i_addr == `OFS_GAIN_EN
      |=> o_rdata == $past(gain_enable_reg))
      else $error("gain enable read back wrong");
   a_read_unmapped: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_rd && !(i_addr inside {`OFS_PAGE_RESET, `OFS_BAND_SEL, `OFS_ENC_SEL, `OFS_GAIN,
                               `OFS_ENC_EN, `OFS_BAND_EN, `OFS_GAIN_EN})
      |=> o_rdata == 8'h00)
      else $error("unmapped address read not zero");

   // write path: only the writable bits land
   a_write_page_reset: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_wr && i_addr == `OFS_PAGE_RESET
      |=> page_reset_reg == $past(i_wdata & `MSK_PAGE_RESET))
      else $error("page reset write not stored");
   a_write_band: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_wr && i_addr == `OFS_BAND_SEL
      |=> sample_band_select_reg == $past(i_wdata & `MSK_BAND_SEL))
      else $error("band select write not stored");
   a_write_format: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_wr && i_addr == `OFS_ENC_SEL
      |=> output_encoding_select_reg == $past(i_wdata & `MSK_ENC_SEL))
      else $error("format select write not stored");
   a_write_gain: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_wr && i_addr == `OFS_GAIN
      |=> signal_gain_setting_reg == $past(i_wdata & `MSK_GAIN))
      else $error("gain setting write not stored");
   a_write_format_enable: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_wr && i_addr == `OFS_ENC_EN
      |=> encoding_control_enable_reg == $past(i_wdata & `MSK_ENC_EN))
      else $error("format enable write not stored");
   a_write_band_enable: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_wr && i_addr == `OFS_BAND_EN
      |=> band_enable_reg == $past(i_wdata & `MSK_BAND_EN))
      else $error("band enable write not stored");
   a_write_gain_enable: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_wr && i_addr == `OFS_GAIN_EN
      |=> gain_enable_reg == $past(i_wdata & `MSK_GAIN_EN))
      else $error("gain enable write not stored");

   // applied settings, held against the shadows as they stood one cycle back
   a_format_forced: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied && !$past(encoding_control_enable_reg[`BIT_ENC_EN])
      |-> o_cfg.encoding == ENC_TWOS)
      else $error("encoding not twos with format enable clear");
   a_format_select: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied
      |-> o_cfg.encoding == sample_enc_t'($past(encoding_control_enable_reg[`BIT_ENC_EN]
                                               & output_encoding_select_reg[`BIT_ENC_SEL])))
      else $error("encoding does not follow select");
   a_format_offset: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied && $past(encoding_control_enable_reg[`BIT_ENC_EN])
         && $past(output_encoding_select_reg[`BIT_ENC_SEL])
      |-> o_cfg.encoding == ENC_OFFSET)
      else $error("offset binary not selected");
   a_zone_gate: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied
      |-> o_cfg.zone_valid == $past(band_enable_reg[`BIT_BAND_EN]))
      else $error("zone enable not applied");
   a_zone_first: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied && o_cfg.zone_valid && $past(sample_band_select_reg[2:0]) == 3'h0
      |-> o_cfg.zone == ZONE_FIRST)
      else $error("zone code 000 not first zone");
   a_zone_second: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied && o_cfg.zone_valid && $past(sample_band_select_reg[2:0]) == 3'h1
      |-> o_cfg.zone == ZONE_SECOND)
      else $error("zone code 001 not second zone");
   a_zone_decode: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied && o_cfg.zone_valid && $past(sample_band_select_reg[2:0]) == 3'h2
      |-> o_cfg.zone == ZONE_THIRD)
      else $error("zone code 010 not third zone");
   a_zone_unused: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied && o_cfg.zone_valid && $past(sample_band_select_reg[2:0]) > 3'h2
      |-> o_cfg.zone == ZONE_NONE)
      else $error("unused zone code accepted");
   a_zone_disabled: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied && !o_cfg.zone_valid
      |-> o_cfg.zone == ZONE_FIRST)
      else $error("zone moved while selection disabled");
   a_gain_enable: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied
      |-> o_cfg.gain_on == $past(gain_enable_reg[`BIT_GAIN_EN]))
      else $error("gain enable not applied");
   a_gain_gate: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied && !o_cfg.gain_on
      |-> o_cfg.gain_code == `GAIN_UNITY)
      else $error("gain applied while disabled");
   a_gain_code: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied && o_cfg.gain_on
      |-> o_cfg.gain_code == $past(signal_gain_setting_reg[6:0]))
      else $error("gain code mismatch");
   a_cfg_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !o_cfg_applied ##1 !o_cfg_applied
      |-> $stable(o_cfg))
      else $error("config changed without page reset pulse");
   a_apply_cause: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied
      |-> $past(i_wr && i_addr == `OFS_PAGE_RESET) && $past(page_reset_reg[`BIT_PAGE_RESET])
         && !page_reset_reg[`BIT_PAGE_RESET])
      else $error("apply without 1 to 0 page reset");
   a_apply_on_fall: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_wr && i_addr == `OFS_PAGE_RESET && page_reset_reg[`BIT_PAGE_RESET]
         && !i_wdata[`BIT_PAGE_RESET]
      |=> o_cfg_applied)
      else $error("page reset fall did not apply settings");
   a_apply_needs_one: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_wr && i_addr == `OFS_PAGE_RESET && !page_reset_reg[`BIT_PAGE_RESET]
      |=> !o_cfg_applied)
      else $error("apply without a stored page reset");
   a_unused_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
      sample_band_select_reg[7:3] == 5'h00
         && encoding_control_enable_reg[4:0] == 5'h00)
      else $error("reserved bit stored");
   a_reserved_rest: assert property (@(posedge i_clk) disable iff (!i_resetn)
      output_encoding_select_reg[7:1] == 7'h00 && band_enable_reg[6:0] == 7'h00
         && gain_enable_reg[7:1] == 7'h00 && page_reset_reg[7:1] == 7'h00
         && encoding_control_enable_reg[7:6] == 2'h0)
      else $error("reserved enable bit stored");

   // main scenarios
   c_apply: cover property (@(posedge i_clk) disable iff (!i_resetn) o_cfg_applied);
   c_offset: cover property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied && o_cfg.encoding == ENC_OFFSET);
   c_gain: cover property (@(posedge i_clk) disable iff (!i_resetn) o_cfg_applied && o_cfg.gain_on);
   c_zone2: cover property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied && o_cfg.zone == ZONE_SECOND);
   c_zone_none: cover property (@(posedge i_clk) disable iff (!i_resetn)
      o_cfg_applied && o_cfg.zone == ZONE_NONE);

endmodule
`default_nettype wire

// ---- output_config_registers_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "out_cfg_defs.svh"
module output_config_registers_tb
   import out_cfg_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] o_rdata;
   active_cfg_t o_cfg;
   logic o_cfg_applied;
   int fails = 0;
   int checks = 0;
   int cyc = 0;
   integer seed = 32'h4a4a_3abd;
   logic rd_d = 1'b0;
   logic [7:0] rq[$];
   active_cfg_t cq[$];
   active_cfg_t cur, x;
   logic [7:0] ofs[7] = '{`OFS_PAGE_RESET, `OFS_BAND_SEL, `OFS_ENC_SEL, `OFS_GAIN, `OFS_ENC_EN,
      `OFS_BAND_EN, `OFS_GAIN_EN};
   logic [7:0] msk[7] = '{`MSK_PAGE_RESET, `MSK_BAND_SEL, `MSK_ENC_SEL, `MSK_GAIN, `MSK_ENC_EN,
      `MSK_BAND_EN, `MSK_GAIN_EN};
   logic [7:0] g, e, b;
   logic [2:0] band;
   logic ben;

   output_config_registers output_config_registers_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cfg(o_cfg), .o_cfg_applied(o_cfg_applied));

   initial begin
      forever #10 i_clk = ~i_clk;
   end

   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         fails++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a; i_wdata <= d; i_wr <= 1'b1; i_rd <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      i_addr <= a; i_rd <= 1'b1; i_wr <= 1'b0;
      rq.push_back(exp);
   endtask

   task idle(input int n);
      repeat (n) begin
         @(posedge i_clk);
         i_wr <= 1'b0; i_rd <= 1'b0;
      end
   endtask

   // read answers stand only in the cycle after the strobe, zero elsewhere
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc > 5000) begin
         fails++;
         close_out;
      end else begin
         // outputs are unknown until the first reset edge, so reset cycles are skipped
         if (i_resetn === 1'b1) begin
            if (rd_d !== 1'b1) chk(o_rdata === 8'h00, "idle read data");
            else if (rq.size() == 0) chk(1'b0, "unexpected read");
            else chk(o_rdata === rq.pop_front(), "read data");
            if (o_cfg_applied === 1'b1) begin
               if (cq.size() == 0) chk(1'b0, "apply without page reset pulse");
               else chk(o_cfg === cq.pop_front(), "applied config");
            end
         end
         rd_d <= i_rd;
      end
   end

   initial begin
      cur = '{ZONE_FIRST, 1'b0, ENC_TWOS, 1'b0, `GAIN_UNITY};
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      @(posedge i_clk);
      chk(o_cfg === cur, "reset config");
      for (int i = 0; i < 7; i++) rd(ofs[i], `REG_RESET);
      // reserved positions must come back as zero
      for (int i = 0; i < 7; i++) begin
         wr(ofs[i], 8'hFF);
         rd(ofs[i], msk[i]);
      end
      wr(8'h10, 8'hFF);
      rd(8'h10, 8'h00);
      for (int i = 0; i < 14; i++) begin
         g = $random(seed); e = $random(seed); b = $random(seed);
         band = (i < 8) ? i[2:0] : b[2:0];
         ben = (i < 8) ? 1'b1 : b[3];
         wr(`OFS_BAND_SEL, {5'h00, band});
         wr(`OFS_ENC_SEL, {7'h00, e[0]});
         wr(`OFS_GAIN, {1'b0, g[6:0]});
         wr(`OFS_ENC_EN, {2'h0, e[1], 5'h00});
         wr(`OFS_BAND_EN, {ben, 7'h00});
         wr(`OFS_GAIN_EN, {7'h00, e[2]});
         rd(`OFS_GAIN, {1'b0, g[6:0]});
         idle(2);
         chk(o_cfg === cur, "config moved before pulse");
         x.zone = !ben ? ZONE_FIRST : (band == 3'h0) ? ZONE_FIRST : (band == 3'h1) ? ZONE_SECOND :
            (band == 3'h2) ? ZONE_THIRD : ZONE_NONE;
         x.zone_valid = ben;
         x.encoding = (e[1] && e[0]) ? ENC_OFFSET : ENC_TWOS;
         x.gain_on = e[2];
         x.gain_code = e[2] ? g[6:0] : `GAIN_UNITY;
         wr(`OFS_PAGE_RESET, 8'h01);
         wr(`OFS_PAGE_RESET, 8'h00);
         cq.push_back(x);
         cur = x;
         idle(3);
      end
      // mid-run reset returns everything to defaults
      @(posedge i_clk);
      i_resetn <= 1'b0;
      idle(2);
      i_resetn <= 1'b1;
      cur = '{ZONE_FIRST, 1'b0, ENC_TWOS, 1'b0, `GAIN_UNITY};
      idle(1);
      chk(o_cfg === cur, "config after second reset");
      rd(`OFS_GAIN, `REG_RESET);
      idle(4);
      chk(rq.size() == 0 && cq.size() == 0, "results missing");
      close_out;
   end
endmodule
`default_nettype wire
